/* File: rtl/uart_bank_params.svh */
// constants for the banked uart register decoder: offsets, fields, resets
`ifndef UART_BANK_PARAMS_SVH
`define UART_BANK_PARAMS_SVH

// register offsets on the three address lines
`define ADDR_HOLD 3'h0
`define ADDR_IEN 3'h1
`define ADDR_ISTAT 3'h2
`define ADDR_LCTL 3'h3
`define ADDR_MCTL 3'h4
`define ADDR_LSTAT 3'h5
`define ADDR_MSTAT 3'h6
`define ADDR_SCR 3'h7

// line control value that opens the enhanced bank
`define KEY_VALUE 8'hbf
// divisor byte value that exposes revision and ident
`define DIV_ZERO 8'h00

// field positions
`define LCTL_DIV 7
`define ENH_BIT 4
`define FEAT_SWAP 6
`define SPF_GPIO 0
`define SPF_TX9 7
`define FRAC_IND 6
`define FRAC_SEL 7
`define FIFO_EN 0
`define FIFO_RXRST 1
`define FIFO_TXRST 2

// bits that exist only while enhanced functions are on
`define IEN_ENH_MASK 8'hf0
`define FCTL_ENH_MASK 8'h38
`define MCTL_ENH_MASK 8'he0
`define ISTAT_ENH_MASK 8'h30

// reset values
`define RST_BYTE 8'h00

// identity codes, arbitrary values
`define DEV_REVISION 8'h01
`define DEV_IDENT 8'h5a

`endif

/* File: rtl/uart_bank_pkg.sv */
// types shared by the banked uart register decoder
package uart_bank_pkg;
    // which register bank the line control contents select
    typedef enum logic [1:0] {
        VIEW_STD = 2'b00,
        VIEW_DIV = 2'b01,
        VIEW_KEY = 2'b10
    } view_t;
    typedef logic [7:0] byte_t;
endpackage

/* File: rtl/uart_banked_register_decode.sv */
// banked register file and address decode for a single-channel uart
// Function
// RULE_01: divisor view, address 0 is divisor low
// RULE_02: zero divisor exposes revision and ident reads
// RULE_03: fraction at 2 needs divisor view, enhanced
// RULE_04: fraction top bits steer divisor high access
// RULE_05: standard view: address 0 receive/transmit
// RULE_06: address 2 reads status, writes fifo control
// RULE_07: status: fifo enables, flow, source code
// RULE_08: address 1 is interrupt enable
// RULE_09: fifo control fields: triggers, wake, resets
// RULE_10: line control at 3 in every view
// RULE_11: modem control fields at address 4
// RULE_12: line status read at address 5
// RULE_13: write 5 loads rs485 setup/hysteresis
// RULE_14: modem status read at address 6
// RULE_15: write 6 loads special function, enhanced
// RULE_16: address 7: scratch or level count
// RULE_17: key view: count, feature, enhanced function
// RULE_18: key view, gpio off: flow characters
// RULE_19: key view, gpio on: gpio registers
// RULE_20: enhanced bits inert and zero unless enabled
// RULE_21: host writes key before enhanced access
`timescale 1ns/100ps
`default_nettype none
`include "uart_bank_params.svh"

module uart_banked_register_decode #(
    parameter logic [7:0] DEVICE_REVISION = `DEV_REVISION, // arbitrary value
    parameter logic [7:0] DEVICE_IDENT = `DEV_IDENT // arbitrary value
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // host bus pins
    input wire logic bus_cs_n,
    input wire logic bus_rd_n,
    input wire logic bus_wr_n,
    input wire logic [2:0] bus_addr,
    input wire logic [7:0] bus_data_in,
    output logic [7:0] bus_data_out,
    output logic bus_data_oe,
    // status from the uart core
    input wire logic [7:0] rx_byte,
    input wire logic [7:0] line_status_in,
    input wire logic [7:0] modem_status_in,
    input wire logic [3:0] int_source,
    input wire logic int_rts_cts,
    input wire logic int_xoff,
    input wire logic [7:0] fifo_level,
    input wire logic [7:0] gpio_pin_level_in,
    // standard control registers
    output logic [7:0] divisor_low_byte,
    output logic [7:0] divisor_high_byte,
    output logic [7:0] divisor_high_byte_rx,
    output logic [7:0] divisor_fraction,
    output logic [7:0] interrupt_enable,
    output logic [7:0] fifo_control,
    output logic [7:0] line_control,
    output logic [7:0] modem_control,
    output logic [7:0] rs485_setup_hysteresis,
    output logic [7:0] special_function,
    output logic [7:0] enhanced_mode_select,
    // enhanced control registers
    output logic [7:0] fifo_threshold_level,
    output logic [7:0] feature_control,
    output logic [7:0] enhanced_function,
    output logic [7:0] resume_char_1,
    output logic [7:0] resume_char_2,
    output logic [7:0] pause_char_1,
    output logic [7:0] pause_char_2,
    output logic [7:0] gpio_interrupt_enable,
    output logic [7:0] gpio_tristate,
    output logic [7:0] gpio_polarity,
    output logic [7:0] gpio_function_select,
    output logic [7:0] gpio_pin_level,
    // transmit byte and one-cycle strobes to the uart core
    output logic [7:0] transmit_holding,
    output logic tx_load,
    output logic threshold_load,
    output logic rx_read,
    output logic line_stat_read,
    output logic modem_stat_read,
    output logic tx_fifo_reset,
    output logic rx_fifo_reset
);

    // pin synchronisers: first stage is read only by the second
    logic [13:0] pin_meta;
    logic [13:0] pin_sync;
    logic rd_prev; // read strobe one cycle ago
    logic wr_prev; // write strobe one cycle ago
    logic [7:0] scratch_pad; // plain storage, no port
    logic [7:0] next_rdata; // read mux result

    // synchronised bus pins
    logic cs_s;
    logic rd_s;
    logic wr_s;
    logic [2:0] addr;
    logic [7:0] wdata;
    assign cs_s = pin_sync[13];
    assign rd_s = pin_sync[12];
    assign wr_s = pin_sync[11];
    assign addr = pin_sync[10:8];
    assign wdata = pin_sync[7:0];

    // access qualifiers
    logic rd_act;
    logic wr_act;
    logic rd_start;
    logic wr_start;
    assign rd_act = !cs_s && !rd_s;
    assign wr_act = !cs_s && !wr_s;
    assign rd_start = rd_act && !rd_prev;
    assign wr_start = wr_act && !wr_prev;

    // bank selection from line control and enhanced enable
    logic key; // line control holds the key value
    logic dlab; // divisor access bit
    logic enh; // enhanced functions on
    logic gpio_bank; // special function gpio access
    logic div_zero; // divisor low byte and addressed high byte both zero
    logic high_rx; // divisor high access steered to the rx copy
    logic [7:0] div_high_sel; // divisor high byte now addressed
    uart_bank_pkg::view_t view;
    assign key = line_control == `KEY_VALUE;
    assign dlab = line_control[`LCTL_DIV];
    assign enh = enhanced_function[`ENH_BIT];
    assign gpio_bank = special_function[`SPF_GPIO];
    // independent rate generator lets the select bit pick the copy [RULE_04]
    assign high_rx = divisor_fraction[`FRAC_IND] && divisor_fraction[`FRAC_SEL];
    assign div_high_sel = high_rx ? divisor_high_byte_rx : divisor_high_byte;
    assign div_zero = divisor_low_byte == `DIV_ZERO && div_high_sel == `DIV_ZERO;

    // key wins over divisor access, since the key also sets bit 7 [RULE_21]
    always_comb
    begin
        if (key)
            view = uart_bank_pkg::VIEW_KEY;
        else if (dlab)
            view = uart_bank_pkg::VIEW_DIV;
        else
            view = uart_bank_pkg::VIEW_STD;
    end

    // per-address decode flags
    logic sel_div_lo;
    logic sel_div_hi;
    logic sel_frac;
    logic sel_key;
    logic sel_std;
    assign sel_key = view == uart_bank_pkg::VIEW_KEY;
    assign sel_std = view == uart_bank_pkg::VIEW_STD;
    assign sel_div_lo = view == uart_bank_pkg::VIEW_DIV && addr == `ADDR_HOLD; // [RULE_01]
    assign sel_div_hi = view == uart_bank_pkg::VIEW_DIV && addr == `ADDR_IEN;
    assign sel_frac = view == uart_bank_pkg::VIEW_DIV && enh && addr == `ADDR_ISTAT; // [RULE_03]

    // address 2 without fraction or key is status/fifo control [RULE_06]
    logic sel_istat;
    assign sel_istat = addr == `ADDR_ISTAT && !sel_key && !sel_frac;

    // two-flop synchronisers on every bus pin
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_meta <= 14'h3800;
            pin_sync <= 14'h3800;
        end
        else
        begin
            pin_meta <= {bus_cs_n, bus_rd_n, bus_wr_n, bus_addr, bus_data_in};
            pin_sync <= pin_meta;
        end
    end

    // strobe history for start detection
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_prev <= 1'b0;
            wr_prev <= 1'b0;
        end
        else
        begin
            rd_prev <= rd_act;
            wr_prev <= wr_act;
        end
    end

    // standard bank: divisor, enables, fifo and line/modem control
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            divisor_low_byte <= `RST_BYTE;
            divisor_high_byte <= `RST_BYTE;
            divisor_high_byte_rx <= `RST_BYTE;
            divisor_fraction <= `RST_BYTE;
            interrupt_enable <= `RST_BYTE;
            fifo_control <= `RST_BYTE;
            line_control <= `RST_BYTE;
            modem_control <= `RST_BYTE;
            rs485_setup_hysteresis <= `RST_BYTE;
        end
        else
        begin
            if (wr_start)
            begin
                if (sel_div_lo)
                    divisor_low_byte <= wdata; // [RULE_01]
                else if (sel_div_hi && high_rx)
                    divisor_high_byte_rx <= wdata; // [RULE_04]
                else if (sel_div_hi)
                    divisor_high_byte <= wdata; // [RULE_04]
                else if (sel_frac)
                    divisor_fraction <= wdata; // [RULE_03]
                else if (sel_std && addr == `ADDR_IEN)
                    interrupt_enable <= wdata; // [RULE_08]
                else if (sel_istat)
                    fifo_control <= wdata; // [RULE_09]
                else if (addr == `ADDR_LCTL)
                    line_control <= wdata; // [RULE_10]
                else if (!sel_key && addr == `ADDR_MCTL)
                    modem_control <= wdata; // [RULE_11]
                else if (!sel_key && addr == `ADDR_LSTAT)
                    rs485_setup_hysteresis <= wdata; // [RULE_13]
            end
            // enhanced bits are held at zero while the enable is off [RULE_20]
            if (!enh)
            begin
                interrupt_enable <= interrupt_enable & ~`IEN_ENH_MASK;
                modem_control <= modem_control & ~`MCTL_ENH_MASK;
                fifo_control <= fifo_control & ~`FCTL_ENH_MASK;
                if (wr_start && sel_std && addr == `ADDR_IEN)
                    interrupt_enable <= wdata & ~`IEN_ENH_MASK;
                else if (wr_start && sel_istat)
                    fifo_control <= wdata & ~`FCTL_ENH_MASK;
                else if (wr_start && !sel_key && addr == `ADDR_MCTL)
                    modem_control <= wdata & ~`MCTL_ENH_MASK;
            end
            // reset bits act once and are not held [RULE_09]
            if (!(wr_start && sel_istat))
                fifo_control[`FIFO_TXRST:`FIFO_RXRST] <= 2'b00;
        end
    end

    // special function, mode select and scratch at addresses 6 and 7
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            special_function <= `RST_BYTE;
            enhanced_mode_select <= `RST_BYTE;
            scratch_pad <= `RST_BYTE;
            gpio_pin_level <= `RST_BYTE;
        end
        else
        begin
            if (wr_start && !sel_key && addr == `ADDR_MSTAT && enh)
                special_function <= wdata; // [RULE_15]
            else if (tx_load)
                special_function[`SPF_TX9] <= 1'b0; // 9th bit rides one byte only
            if (wr_start && !sel_key && addr == `ADDR_SCR)
            begin
                // swap bit picks mode select, else scratch or gpio level [RULE_16]
                if (feature_control[`FEAT_SWAP])
                    enhanced_mode_select <= wdata;
                else if (gpio_bank)
                    gpio_pin_level <= wdata;
                else
                    scratch_pad <= wdata;
            end
        end
    end

    // key bank registers [RULE_17] [RULE_18] [RULE_19]
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fifo_threshold_level <= `RST_BYTE;
            feature_control <= `RST_BYTE;
            enhanced_function <= `RST_BYTE;
            resume_char_1 <= `RST_BYTE;
            resume_char_2 <= `RST_BYTE;
            pause_char_1 <= `RST_BYTE;
            pause_char_2 <= `RST_BYTE;
            gpio_interrupt_enable <= `RST_BYTE;
            gpio_tristate <= `RST_BYTE;
            gpio_polarity <= `RST_BYTE;
            gpio_function_select <= `RST_BYTE;
        end
        else if (wr_start && sel_key)
        begin
            if (addr == `ADDR_HOLD)
                fifo_threshold_level <= wdata; // [RULE_17]
            else if (addr == `ADDR_IEN)
                feature_control <= wdata; // [RULE_17]
            else if (addr == `ADDR_ISTAT)
                enhanced_function <= wdata; // [RULE_17]
            else if (gpio_bank && addr == `ADDR_MCTL)
                gpio_interrupt_enable <= wdata; // [RULE_19]
            else if (gpio_bank && addr == `ADDR_LSTAT)
                gpio_tristate <= wdata; // [RULE_19]
            else if (gpio_bank && addr == `ADDR_MSTAT)
                gpio_polarity <= wdata; // [RULE_19]
            else if (gpio_bank && addr == `ADDR_SCR)
                gpio_function_select <= wdata; // [RULE_19]
            else if (addr == `ADDR_MCTL)
                resume_char_1 <= wdata; // [RULE_18]
            else if (addr == `ADDR_LSTAT)
                resume_char_2 <= wdata; // [RULE_18]
            else if (addr == `ADDR_MSTAT)
                pause_char_1 <= wdata; // [RULE_18]
            else if (addr == `ADDR_SCR)
                pause_char_2 <= wdata; // [RULE_18]
        end
    end

    // strobes to the core, one cycle after the access starts
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            transmit_holding <= `RST_BYTE;
            tx_load <= 1'b0;
            threshold_load <= 1'b0;
            rx_read <= 1'b0;
            line_stat_read <= 1'b0;
            modem_stat_read <= 1'b0;
            tx_fifo_reset <= 1'b0;
            rx_fifo_reset <= 1'b0;
        end
        else
        begin
            tx_load <= wr_start && sel_std && addr == `ADDR_HOLD; // [RULE_05]
            if (wr_start && sel_std && addr == `ADDR_HOLD)
                transmit_holding <= wdata; // [RULE_05]
            threshold_load <= wr_start && sel_key && addr == `ADDR_HOLD;
            rx_read <= rd_start && sel_std && addr == `ADDR_HOLD;
            line_stat_read <= rd_start && !sel_key && addr == `ADDR_LSTAT;
            // delta flags in the core clear on this strobe
            modem_stat_read <= rd_start && !sel_key && addr == `ADDR_MSTAT;
            tx_fifo_reset <= wr_start && sel_istat && wdata[`FIFO_TXRST]; // [RULE_09]
            rx_fifo_reset <= wr_start && sel_istat && wdata[`FIFO_RXRST]; // [RULE_09]
        end
    end

    // read mux: line control, then key bank, then divisor and standard banks
    always_comb
    begin
        next_rdata = `RST_BYTE;
        if (addr == `ADDR_LCTL)
            next_rdata = line_control; // [RULE_10]
        else if (sel_key)
        begin
            if (addr == `ADDR_HOLD)
                next_rdata = fifo_level; // [RULE_17]
            else if (addr == `ADDR_IEN)
                next_rdata = feature_control;
            else if (addr == `ADDR_ISTAT)
                next_rdata = enhanced_function;
            else if (gpio_bank && addr == `ADDR_MCTL)
                next_rdata = gpio_interrupt_enable; // [RULE_19]
            else if (gpio_bank && addr == `ADDR_LSTAT)
                next_rdata = gpio_tristate;
            else if (gpio_bank && addr == `ADDR_MSTAT)
                next_rdata = gpio_polarity;
            else if (gpio_bank)
                next_rdata = gpio_function_select;
            else if (addr == `ADDR_MCTL)
                next_rdata = resume_char_1; // [RULE_18]
            else if (addr == `ADDR_LSTAT)
                next_rdata = resume_char_2;
            else if (addr == `ADDR_MSTAT)
                next_rdata = pause_char_1;
            else
                next_rdata = pause_char_2;
        end
        else if (sel_div_lo)
            next_rdata = div_zero ? DEVICE_REVISION : divisor_low_byte; // [RULE_02]
        else if (sel_div_hi)
            next_rdata = div_zero ? DEVICE_IDENT : div_high_sel; // [RULE_02] [RULE_04]
        else if (sel_frac)
            next_rdata = divisor_fraction;
        else if (addr == `ADDR_HOLD)
            next_rdata = rx_byte; // [RULE_05]
        else if (addr == `ADDR_IEN)
            next_rdata = interrupt_enable; // [RULE_08]
        else if (addr == `ADDR_ISTAT)
            // upper flow bits only while enhanced is on [RULE_07] [RULE_20]
            next_rdata = {{2{fifo_control[`FIFO_EN]}}, int_rts_cts, int_xoff, int_source}
                & (enh ? 8'hff : ~`ISTAT_ENH_MASK);
        else if (addr == `ADDR_MCTL)
            next_rdata = modem_control; // [RULE_11]
        else if (addr == `ADDR_LSTAT)
            next_rdata = line_status_in; // [RULE_12]
        else if (addr == `ADDR_MSTAT)
            next_rdata = modem_status_in; // [RULE_14]
        else if (feature_control[`FEAT_SWAP])
            next_rdata = fifo_level; // [RULE_16]
        else if (gpio_bank)
            next_rdata = gpio_pin_level_in;
        else
            next_rdata = scratch_pad; // [RULE_16]
    end

    // data pins driven only while a read strobe is seen
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus_data_out <= `RST_BYTE;
            bus_data_oe <= 1'b0;
        end
        else
        begin
            bus_data_oe <= rd_act;
            bus_data_out <= rd_act ? next_rdata : `RST_BYTE;
        end
    end

    // checks
    sequence rx_reset_pulse;
        rx_fifo_reset ##1 !rx_fifo_reset;
    endsequence

    chk_div_low_write: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_01]
        wr_start && sel_div_lo |=> divisor_low_byte == $past(wdata))
        else $error("divisor low write lost");
    chk_ident_read: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_02]
        rd_act && sel_div_hi && div_zero |=> bus_data_out == DEVICE_IDENT)
        else $error("ident not shown for zero divisor");
    chk_fraction_gate: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_03]
        wr_start && addr == `ADDR_ISTAT && !enh |=> $stable(divisor_fraction))
        else $error("fraction written without enhanced enable");
    chk_tx_load_data: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_05]
        wr_start && sel_std && addr == `ADDR_HOLD |=> tx_load && transmit_holding == $past(wdata))
        else $error("transmit holding load missed");
    chk_rx_reset: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_09]
        wr_start && sel_istat && wdata[`FIFO_RXRST] |=> rx_reset_pulse)
        else $error("rx fifo reset not a single pulse");
    chk_status_read: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_12]
        rd_act && !sel_key && addr == `ADDR_LSTAT |=> bus_data_out == $past(line_status_in))
        else $error("line status read wrong");
    chk_enh_func_write: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_17]
        wr_start && sel_key && addr == `ADDR_ISTAT |=> enhanced_function == $past(wdata))
        else $error("enhanced function write lost");
    chk_gpio_bank: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_19]
        wr_start && sel_key && gpio_bank && addr == `ADDR_MCTL
        |=> gpio_interrupt_enable == $past(wdata) && $stable(resume_char_1))
        else $error("gpio bank write misrouted");
    chk_enh_zero: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_20]
        !enh ##1 !enh |-> (interrupt_enable & `IEN_ENH_MASK) == 8'h00
        && (modem_control & `MCTL_ENH_MASK) == 8'h00)
        else $error("enhanced bits live while disabled");

endmodule // uart_banked_register_decode

`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the banked uart register decoder
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam logic [7:0] REV = 8'h3c; // arbitrary revision code
    localparam logic [7:0] IDN = 8'hc3; // arbitrary ident code
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] stat = 8'h6b; // feeds every core status input
    logic cs_n, rd_n, wr_n, oe;
    logic [2:0] addr;
    logic [7:0] din, dout, rdat;
    int error_cnt = 0;
    int total_checks = 0;
    always #2.5 core_clk = ~core_clk;
    uart_host_model i_host (.core_clk(core_clk), .bus_cs_n(cs_n), .bus_rd_n(rd_n),
        .bus_wr_n(wr_n), .bus_addr(addr), .bus_data_in(din), .bus_data_out(dout),
        .bus_data_oe(oe));
    uart_banked_register_decode #(.DEVICE_REVISION(REV), .DEVICE_IDENT(IDN)) i_dut (
        .core_clk(core_clk), .arst_n(arst_n), .bus_cs_n(cs_n), .bus_rd_n(rd_n),
        .bus_wr_n(wr_n), .bus_addr(addr), .bus_data_in(din), .bus_data_out(dout),
        .bus_data_oe(oe), .rx_byte(stat), .line_status_in(~stat),
        .modem_status_in({stat[3:0], stat[7:4]}), .int_source(stat[3:0]),
        .int_rts_cts(stat[5]), .int_xoff(stat[4]), .fifo_level(stat ^ 8'h0f),
        .gpio_pin_level_in(stat ^ 8'hf0), .divisor_low_byte(), .divisor_high_byte(),
        .divisor_high_byte_rx(), .divisor_fraction(), .interrupt_enable(),
        .fifo_control(), .line_control(), .modem_control(), .rs485_setup_hysteresis(),
        .special_function(), .enhanced_mode_select(), .fifo_threshold_level(),
        .feature_control(), .enhanced_function(), .resume_char_1(), .resume_char_2(),
        .pause_char_1(), .pause_char_2(), .gpio_interrupt_enable(), .gpio_tristate(),
        .gpio_polarity(), .gpio_function_select(), .gpio_pin_level(),
        .transmit_holding(), .tx_load(), .threshold_load(), .rx_read(), .line_stat_read(),
        .modem_stat_read(), .tx_fifo_reset(), .rx_fifo_reset());
    // verdict, reached from the end of the run and from a dead bus
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // byte comparison, four-state exact
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // read and compare; a read that never answers ends the run
    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
        i_host.read_reg(a, rdat);
        if (i_host.timed_out)
        begin
            error_cnt++;
            tally_and_finish();
        end
        else
            chk(what, exp, rdat);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        i_host.write_reg(a, d);
    endtask
    initial
    begin
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        arst_n = 1'b1;
        // standard view, enhanced bits still locked
        rd(3'h3, 8'h00, "line ctl reset");
        wr(3'h0, 8'ha7);
        chk("tx holding", 8'ha7, i_dut.transmit_holding);
        rd(3'h0, 8'h6b, "rx holding");
        rd(3'h5, 8'h94, "line status");
        rd(3'h6, 8'hb6, "modem status");
        wr(3'h1, 8'hff);
        rd(3'h1, 8'h0f, "int enable locked");
        wr(3'h2, 8'hff);
        chk("fifo ctl", 8'hc1, i_dut.fifo_control);
        rd(3'h2, 8'hcb, "int status locked");
        wr(3'h7, 8'ha5);
        rd(3'h7, 8'ha5, "scratch");
        wr(3'h5, 8'h3c);
        chk("rs485 setup", 8'h3c, i_dut.rs485_setup_hysteresis);
        wr(3'h6, 8'h01);
        chk("special locked", 8'h00, i_dut.special_function);
        $display("standard view done");
        // divisor view: zero divisor shows identity codes first
        wr(3'h3, 8'h80);
        rd(3'h0, REV, "revision");
        rd(3'h1, IDN, "ident");
        wr(3'h0, 8'h12);
        rd(3'h0, 8'h12, "div low");
        wr(3'h1, 8'h34);
        wr(3'h2, 8'hc0);
        chk("fraction locked", 8'h00, i_dut.divisor_fraction);
        chk("fifo ctl via div", 8'hc0, i_dut.fifo_control);
        rd(3'h3, 8'h80, "line ctl");
        $display("divisor view done");
        // key view with flow characters
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h10);
        rd(3'h2, 8'h10, "enh function");
        wr(3'h1, 8'h40);
        rd(3'h1, 8'h40, "feature ctl");
        wr(3'h0, 8'h2e);
        chk("threshold", 8'h2e, i_dut.fifo_threshold_level);
        rd(3'h0, 8'h64, "level");
        for (int i = 4; i < 8; i++)
        begin
            wr(i[2:0], {5'h10, i[2:0]});
        end
        for (int i = 4; i < 8; i++)
        begin
            rd(i[2:0], {5'h10, i[2:0]}, "flow char");
        end
        $display("key view done");
        // divisor view, enhanced on: fraction steers the high byte
        wr(3'h3, 8'h80);
        wr(3'h2, 8'hc0);
        rd(3'h2, 8'hc0, "fraction");
        wr(3'h1, 8'h77);
        chk("div high rx", 8'h77, i_dut.divisor_high_byte_rx);
        chk("div high", 8'h34, i_dut.divisor_high_byte);
        $display("fraction done");
        // standard view, enhanced on, then gpio bank
        wr(3'h3, 8'h03);
        stat = 8'h39;
        rd(3'h7, 8'h36, "level alt");
        wr(3'h7, 8'h99);
        chk("mode select", 8'h99, i_dut.enhanced_mode_select);
        wr(3'h1, 8'hff);
        rd(3'h1, 8'hff, "int enable open");
        wr(3'h4, 8'hff);
        rd(3'h4, 8'hff, "modem ctl");
        rd(3'h2, 8'h39, "int status open");
        wr(3'h6, 8'h01);
        chk("special fn", 8'h01, i_dut.special_function);
        wr(3'h3, 8'hbf);
        for (int i = 4; i < 8; i++)
        begin
            wr(i[2:0], {5'h08, i[2:0]});
            rd(i[2:0], {5'h08, i[2:0]}, "gpio reg");
        end
        chk("gpio int", 8'h44, i_dut.gpio_interrupt_enable);
        chk("xon kept", 8'h84, i_dut.resume_char_1);
        $display("gpio view done");
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire

/* File: verification/uart_host_model.sv */
// host processor model that drives the uart register bus pins
`timescale 1ns/100ps
`default_nettype none
module uart_host_model (
    // clock
    input wire logic core_clk,
    // bus pins
    output logic bus_cs_n,
    output logic bus_rd_n,
    output logic bus_wr_n,
    output logic [2:0] bus_addr,
    output logic [7:0] bus_data_in,
    input wire logic [7:0] bus_data_out,
    input wire logic bus_data_oe
);
    logic timed_out = 1'b0; // last read saw no answer
    initial
    begin
        bus_cs_n = 1'b1;
        bus_rd_n = 1'b1;
        bus_wr_n = 1'b1;
        bus_addr = 3'h0;
        bus_data_in = 8'h00;
    end
    // drop strobes, hold lines until the sync has seen the end, then scramble them
    task automatic release_bus();
        bus_cs_n = 1'b1;
        bus_rd_n = 1'b1;
        bus_wr_n = 1'b1;
        repeat (3) @(negedge core_clk);
        bus_addr = ~bus_addr; // released lines never keep a stale value
        bus_data_in = ~bus_data_in;
        @(negedge core_clk);
    endtask
    // address settles two edges before the strobes, as the sync needs
    task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
        @(negedge core_clk);
        bus_addr = a;
        bus_data_in = d;
        repeat (2) @(negedge core_clk);
        bus_cs_n = 1'b0;
        bus_wr_n = 1'b0;
        repeat (4) @(negedge core_clk);
        release_bus();
    endtask
    // read waits for the output enable under a bound
    task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
        int n;
        @(negedge core_clk);
        bus_addr = a;
        repeat (2) @(negedge core_clk);
        bus_cs_n = 1'b0;
        bus_rd_n = 1'b0;
        n = 0;
        while (bus_data_oe !== 1'b1 && n < 8)
        begin
            @(negedge core_clk);
            n++;
        end
        timed_out = (bus_data_oe !== 1'b1);
        d = bus_data_out;
        release_bus();
    endtask
endmodule // uart_host_model
`default_nettype wire
